// ### include/alu_params.svh
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH
`define STATUS_FLAGS_ADDR 6'h3F
`define STATUS_FLAGS_RESET 8'h00
`define FLAG_I 7
`define FLAG_T 6
`define FLAG_H 5
`define FLAG_S 4
`define FLAG_V 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`endif

// ### include/alu_pkg.sv
package alu_pkg;
   typedef enum logic [3:0] {
      OP_NONE                          = 4'h0,
      OP_ADD                           = 4'h1,
      OP_ADD_CARRY                     = 4'h2,
      OP_SUB                           = 4'h3,
      subtract_with_borrow_op          = 4'h4,
      subtract_immediate_op            = 4'h5,
      subtract_immediate_borrow_op     = 4'h6,
      OP_AND                           = 4'h7,
      and_immediate_op                 = 4'h8,
      OP_OR                            = 4'h9,
      or_immediate_op                  = 4'hA
   } alu_op_t;

   typedef struct packed {
      alu_op_t    op;
      logic [4:0] dest_index;
      logic [7:0] dest_value;
      logic [7:0] source_register;
      logic [7:0] constant;
   } alu_req_t;

   typedef struct packed {
      logic       valid;
      logic [4:0] dest_index;
      logic [7:0] value;
   } alu_wb_t;
endpackage

// ### rtl/alu_arith_logic_flags.sv
`timescale 1ns/1ns
`default_nettype none
`include "alu_params.svh"
module alu_arith_logic_flags (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Decoder request
   input  wire logic              req_valid,
   input  wire alu_pkg::alu_req_t req,
   // Register file write-back
   output var alu_pkg::alu_wb_t   wb,
   // Status register port
   input  wire logic [5:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [7:0]        reg_rdata,
   // Flags to branch logic
   output logic      [7:0]        status_flags
);
   logic [3:0] op_eff;
   logic [7:0] operand_b;
   logic [7:0] result;
   logic [7:0] next_flags;
   logic       imm;
   logic       op_taken;
   logic       sw_write;

   // Decoding shared by the operand mux and the checks below
   function automatic logic is_imm_op(input logic [3:0] code);
      return (code == alu_pkg::subtract_immediate_op)
         || (code == alu_pkg::subtract_immediate_borrow_op)
         || (code == alu_pkg::and_immediate_op)
         || (code == alu_pkg::or_immediate_op);
   endfunction

   function automatic logic is_and_op(input logic [3:0] code);
      return (code == alu_pkg::OP_AND) || (code == alu_pkg::and_immediate_op);
   endfunction

   function automatic logic is_or_op(input logic [3:0] code);
      return (code == alu_pkg::OP_OR) || (code == alu_pkg::or_immediate_op);
   endfunction

   always_comb begin
      imm       = is_imm_op(req.op);
      operand_b = imm ? req.constant : req.source_register;
      op_eff    = req_valid ? req.op : alu_pkg::OP_NONE;
      op_taken  = req_valid && (req.op != alu_pkg::OP_NONE);
      sw_write  = reg_write && (reg_addr == `STATUS_FLAGS_ADDR);
   end

   alu_core u_core (
      .op        (op_eff),
      .a         (req.dest_value),
      .b         (operand_b),
      .flags_in  (status_flags),
      .result    (result),
      .flags_out (next_flags)
   );

   // Operation wins over a same-cycle software write
   always_ff @(posedge clk) begin
      if (!resetn)
         status_flags <= `STATUS_FLAGS_RESET;
      else if (op_taken)
         status_flags <= next_flags;
      else if (sw_write)
         status_flags <= reg_wdata;
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         wb <= '0;
      else begin
         wb.valid      <= op_taken;
         wb.dest_index <= req.dest_index;
         wb.value      <= result;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         reg_rdata <= 8'h00;
      else if (reg_read && reg_addr == `STATUS_FLAGS_ADDR)
         reg_rdata <= status_flags;
      else
         reg_rdata <= 8'h00;
   end

   property p_add_one_clock;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_ADD |=>
         wb.valid && wb.value == $past(req.dest_value) + $past(req.source_register);
   endproperty
   a_add_one_clock: assert property (p_add_one_clock) else $error("add wrong");

   property p_sub_flags;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_SUB |=>
         status_flags[`FLAG_C] == ($past(req.dest_value) < $past(req.source_register));
   endproperty
   a_sub_flags: assert property (p_sub_flags) else $error("sub carry wrong");

   property p_subtract_immediate_op_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::subtract_immediate_op |=>
         wb.value == $past(req.dest_value) - $past(req.constant);
   endproperty
   a_subtract_immediate_op_value: assert property (p_subtract_immediate_op_value) else $error("subtract_immediate_op wrong");

   property p_and_keeps_c;
      @(posedge clk) disable iff (!resetn)
      req_valid && (req.op == alu_pkg::OP_AND || req.op == alu_pkg::and_immediate_op)
         |=> $stable(status_flags[`FLAG_C]) && !status_flags[`FLAG_V];
   endproperty
   a_and_keeps_c: assert property (p_and_keeps_c) else $error("and flags wrong");

   property p_or_zero;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_OR |=>
         status_flags[`FLAG_Z] == (wb.value == 8'h00) && $stable(status_flags[`FLAG_H]);
   endproperty
   a_or_zero: assert property (p_or_zero) else $error("or flags wrong");

   property p_keep_it;
      @(posedge clk) disable iff (!resetn)
      op_taken |=> $stable(status_flags[`FLAG_I]) && $stable(status_flags[`FLAG_T]);
   endproperty
   a_keep_it: assert property (p_keep_it) else $error("I or T changed");

   // Request taken at this edge
   sequence s_taken;
      op_taken;
   endsequence

   // Write-back one edge later, aimed at the requested register
   sequence s_written;
      wb.valid && (wb.dest_index == $past(req.dest_index));
   endsequence

   // Software write with no operation beside it
   sequence s_sw_only;
      sw_write && !op_taken;
   endsequence

   // Status read strobe
   sequence s_status_read;
      reg_read && (reg_addr == `STATUS_FLAGS_ADDR);
   endsequence

   property p_wb_one_clock;
      @(posedge clk) disable iff (!resetn)
      s_taken |=> s_written;
   endproperty
   a_wb_one_clock: assert property (p_wb_one_clock) else $error("write-back late");

   property p_wb_idle;
      @(posedge clk) disable iff (!resetn)
      !op_taken |=> !wb.valid;
   endproperty
   a_wb_idle: assert property (p_wb_idle) else $error("write-back without request");

   property p_adc_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_ADD_CARRY |=>
         wb.value == $past(req.dest_value) + $past(req.source_register)
            + $past(status_flags[`FLAG_C]);
   endproperty
   a_adc_value: assert property (p_adc_value) else $error("add with carry wrong");

   property p_add_carry;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_ADD |=>
         status_flags[`FLAG_C] == (wb.value < $past(req.dest_value));
   endproperty
   a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

   property p_add_half;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_ADD |=>
         status_flags[`FLAG_H] == (wb.value[3:0] < $past(req.dest_value[3:0]));
   endproperty
   a_add_half: assert property (p_add_half) else $error("add half carry wrong");

   property p_add_overflow;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_ADD |=>
         status_flags[`FLAG_V] == (($past(req.dest_value[7]) == $past(req.source_register[7]))
            && (wb.value[7] != $past(req.dest_value[7])));
   endproperty
   a_add_overflow: assert property (p_add_overflow) else $error("add overflow wrong");

   property p_sbc_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::subtract_with_borrow_op |=>
         wb.value == $past(req.dest_value) - $past(req.source_register)
            - $past(status_flags[`FLAG_C]);
   endproperty
   a_sbc_value: assert property (p_sbc_value) else $error("borrow subtract wrong");

   property p_sub_half;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_SUB |=>
         status_flags[`FLAG_H]
            == ($past(req.dest_value[3:0]) < $past(req.source_register[3:0]));
   endproperty
   a_sub_half: assert property (p_sub_half) else $error("sub half borrow wrong");

   property p_sub_overflow;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_SUB |=>
         status_flags[`FLAG_V] == (($past(req.dest_value[7]) != $past(req.source_register[7]))
            && (wb.value[7] != $past(req.dest_value[7])));
   endproperty
   a_sub_overflow: assert property (p_sub_overflow) else $error("sub overflow wrong");

   property p_subtract_immediate_borrow_op_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::subtract_immediate_borrow_op |=>
         wb.value == $past(req.dest_value) - $past(req.constant)
            - $past(status_flags[`FLAG_C]);
   endproperty
   a_subtract_immediate_borrow_op_value: assert property (p_subtract_immediate_borrow_op_value) else $error("borrow subtract_immediate_op wrong");

   property p_subtract_immediate_op_carry;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::subtract_immediate_op |=>
         status_flags[`FLAG_C] == ($past(req.dest_value) < $past(req.constant));
   endproperty
   a_subtract_immediate_op_carry: assert property (p_subtract_immediate_op_carry) else $error("subtract_immediate_op carry wrong");

   property p_and_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_AND |=>
         wb.value == ($past(req.dest_value) & $past(req.source_register));
   endproperty
   a_and_value: assert property (p_and_value) else $error("and value wrong");

   property p_and_immediate_op_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::and_immediate_op |=>
         wb.value == ($past(req.dest_value) & $past(req.constant));
   endproperty
   a_and_immediate_op_value: assert property (p_and_immediate_op_value) else $error("and constant wrong");

   property p_and_keeps_h;
      @(posedge clk) disable iff (!resetn)
      req_valid && is_and_op(req.op) |=>
         $stable(status_flags[`FLAG_H]) && (status_flags[`FLAG_N] == wb.value[7]);
   endproperty
   a_and_keeps_h: assert property (p_and_keeps_h) else $error("and flags wrong");

   property p_or_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::OP_OR |=>
         wb.value == ($past(req.dest_value) | $past(req.source_register));
   endproperty
   a_or_value: assert property (p_or_value) else $error("or value wrong");

   property p_ori_value;
      @(posedge clk) disable iff (!resetn)
      req_valid && req.op == alu_pkg::or_immediate_op |=>
         wb.value == ($past(req.dest_value) | $past(req.constant));
   endproperty
   a_ori_value: assert property (p_ori_value) else $error("or constant wrong");

   property p_or_keeps;
      @(posedge clk) disable iff (!resetn)
      req_valid && is_or_op(req.op) |=>
         $stable(status_flags[`FLAG_C]) && $stable(status_flags[`FLAG_H])
            && !status_flags[`FLAG_V];
   endproperty
   a_or_keeps: assert property (p_or_keeps) else $error("or flags wrong");

   property p_zero_flag;
      @(posedge clk) disable iff (!resetn)
      s_taken |=> status_flags[`FLAG_Z] == (wb.value == 8'h00);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   property p_neg_flag;
      @(posedge clk) disable iff (!resetn)
      s_taken |=> status_flags[`FLAG_N] == wb.value[7];
   endproperty
   a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");

   property p_op_beats_write;
      @(posedge clk) disable iff (!resetn)
      s_taken ##0 sw_write |=>
         $stable(status_flags[`FLAG_I]) && $stable(status_flags[`FLAG_T]);
   endproperty
   a_op_beats_write: assert property (p_op_beats_write) else $error("write beat op");

   property p_sw_write;
      @(posedge clk) disable iff (!resetn)
      s_sw_only |=> status_flags == $past(reg_wdata);
   endproperty
   a_sw_write: assert property (p_sw_write) else $error("status write lost");

   property p_quiet_keeps;
      @(posedge clk) disable iff (!resetn)
      !op_taken && !sw_write |=> $stable(status_flags);
   endproperty
   a_quiet_keeps: assert property (p_quiet_keeps) else $error("status changed idle");

   property p_read_back;
      @(posedge clk) disable iff (!resetn)
      s_status_read |=> reg_rdata == $past(status_flags);
   endproperty
   a_read_back: assert property (p_read_back) else $error("status read wrong");

   property p_read_other;
      @(posedge clk) disable iff (!resetn)
      !(reg_read && reg_addr == `STATUS_FLAGS_ADDR) |=> reg_rdata == 8'h00;
   endproperty
   a_read_other: assert property (p_read_other) else $error("read data not zero");
endmodule
`default_nettype wire

// ### rtl/alu_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "alu_params.svh"
module alu_core (
   // Operation
   input  wire logic [3:0] op,
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic [7:0] flags_in,
   // Result
   output logic      [7:0] result,
   output logic      [7:0] flags_out
);
   logic       cin;
   logic       is_sub;
   logic       is_logic;
   logic [8:0] wide;
   logic [4:0] low;
   logic [7:0] f;

   always_comb begin
      is_sub = (op == alu_pkg::OP_SUB) || (op == alu_pkg::subtract_with_borrow_op)
            || (op == alu_pkg::subtract_immediate_op)
            || (op == alu_pkg::subtract_immediate_borrow_op);
      is_logic = (op >= alu_pkg::OP_AND) && (op <= alu_pkg::or_immediate_op);
      cin = ((op == alu_pkg::OP_ADD_CARRY) || (op == alu_pkg::subtract_with_borrow_op)
            || (op == alu_pkg::subtract_immediate_borrow_op)) && flags_in[`FLAG_C];
      if (is_sub) begin
         wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      end else begin
         wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      end
      f = flags_in;
      if (is_logic) begin
         if ((op == alu_pkg::OP_AND) || (op == alu_pkg::and_immediate_op))
            result = a & b;
         else
            result = a | b;
         f[`FLAG_V] = 1'b0;
         f[`FLAG_N] = result[7];
         f[`FLAG_Z] = (result == 8'h00);
      end else if (op != alu_pkg::OP_NONE) begin
         result = wide[7:0];
         f[`FLAG_C] = wide[8];
         f[`FLAG_H] = low[4];
         f[`FLAG_N] = result[7];
         f[`FLAG_Z] = (result == 8'h00);
         if (is_sub)
            f[`FLAG_V] = (a[7] & ~b[7] & ~result[7]) | (~a[7] & b[7] & result[7]);
         else
            f[`FLAG_V] = (a[7] & b[7] & ~result[7]) | (~a[7] & ~b[7] & result[7]);
      end else begin
         result = 8'h00;
      end
      if (op != alu_pkg::OP_NONE)
         f[`FLAG_S] = f[`FLAG_N] ^ f[`FLAG_V];
      flags_out = f;
   end
endmodule
`default_nettype wire

// ### sim/alu_partner.sv
`timescale 1ns/1ns
`default_nettype none
module alu_partner (
   // Clock
   input  wire logic             clk,
   // Operand selection
   input  wire logic [4:0]       dst,
   input  wire logic [4:0]       src,
   output logic      [7:0]       dst_val,
   output logic      [7:0]       src_val,
   // Write-back
   input  wire alu_pkg::alu_wb_t wb
);
   // Plain always so the bench may preload it
   logic [7:0] regs [32];
   assign dst_val = regs[dst];
   assign src_val = regs[src];
   always @(posedge clk) begin
      if (wb.valid === 1'b1) begin
         regs[wb.dest_index] <= wb.value;
      end
   end
endmodule
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [63:0] PRELOAD = 64'h00010F7F80FF3CC3;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic              req_valid = 1'b0;
   logic [3:0]        op = 4'h0;
   logic [4:0]        dst = 5'h00;
   logic [4:0]        src = 5'h00;
   logic [7:0]        k = 8'h00;
   logic [7:0]        dv, sv, reg_rdata, status_flags, sr;
   logic [7:0]        xr [32];
   alu_pkg::alu_req_t req;
   alu_pkg::alu_wb_t  wb;
   logic [5:0]        reg_addr = 6'h00;
   logic [7:0]        reg_wdata = 8'h00;
   logic              reg_write = 1'b0;
   logic              reg_read = 1'b0;
   int                n_errors = 0;
   int                compares = 0;
   always #5 clk = ~clk;
   assign req = '{alu_pkg::alu_op_t'(op), dst, dv, sv, k};
   alu_arith_logic_flags i_alu_arith_logic_flags (.clk, .resetn, .req_valid, .req, .wb,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .status_flags);
   alu_partner i_alu_partner (.clk, .dst, .src, .dst_val(dv), .src_val(sv), .wb);
   function automatic logic [15:0] calc(logic [3:0] o, logic [7:0] a, b, c, f);
      logic [8:0] r;
      logic [7:0] q;
      logic       h, v, cy;
      q = (o == 4'h5 || o == 4'h6 || o == 4'h8 || o == 4'hA) ? c : b;
      cy = (o == 4'h2 || o == 4'h4 || o == 4'h6) & f[0];
      if (o <= 4'h2) begin
         r = a + q + cy;
         h = a[3:0] + q[3:0] + cy > 15;
         v = a[7] == q[7] && r[7] != a[7];
      end else if (o <= 4'h6) begin
         r = a - q - cy;
         h = {1'b0, a[3:0]} < {1'b0, q[3:0]} + cy;
         v = a[7] != q[7] && r[7] != a[7];
      end else begin
         // Logic ops leave carry and half carry alone
         r = {f[0], (o <= 4'h8) ? a & q : a | q};
         h = f[5];
         v = 1'b0;
      end
      return {r[7:0], f[7:6], h, r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]};
   endfunction
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(logic [5:0] a, logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(logic [5:0] a, logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // Two idle cycles between ops: the model has no forwarding
   task automatic do_op(logic [3:0] o, logic [4:0] d, s, logic [7:0] c, logic clash);
      logic [15:0] e;
      e = calc(o, xr[d], xr[s], c, sr);
      @(posedge clk);
      op <= o;
      dst <= d;
      src <= s;
      k <= c;
      req_valid <= 1'b1;
      // Optional status write beside the op; the op must win
      reg_addr <= 6'h3F;
      reg_wdata <= ~sr;
      reg_write <= clash;
      @(posedge clk);
      req_valid <= 1'b0;
      reg_write <= 1'b0;
      // Write-back stands for this one cycle only
      #1;
      xr[d] = e[15:8];
      sr = e[7:0];
      chk({7'h00, wb.valid}, 8'h01);
      chk({3'h0, wb.dest_index}, {3'h0, d});
      chk(wb.value, e[15:8]);
      chk(status_flags, e[7:0]);
      @(posedge clk);
      #1;
      chk(i_alu_partner.regs[d], e[15:8]);
   endtask
   task automatic t_regs;
      rd(6'h3F, 8'h00);
      wr(6'h3F, 8'hC5);
      rd(6'h3F, 8'hC5);
      chk(status_flags, 8'hC5);
      wr(6'h3E, 8'h12);
      rd(6'h3E, 8'h00);
      rd(6'h3F, 8'hC5);
      sr = 8'hC5;
   endtask
   task automatic t_arith;
      for (int o = 1; o <= 6; o++) begin
         for (int d = 0; d < 8; d++) begin
            do_op(4'(o), 5'(d), 5'((d + 3) % 8), 8'h01 << d, 1'b0);
         end
      end
   endtask
   task automatic t_logic;
      wr(6'h3F, 8'hFF);
      sr = 8'hFF;
      for (int o = 7; o <= 10; o++) begin
         for (int d = 0; d < 8; d++) begin
            do_op(4'(o), 5'(d), 5'((d + 5) % 8), 8'hF0 >> d, 1'b0);
         end
      end
      do_op(4'h9, 5'h01, 5'h02, 8'h00, 1'b1);
   endtask
   initial begin
      for (int i = 0; i < 32; i++) begin
         xr[i] = (i < 8) ? PRELOAD[63 - 8 * i -: 8] : 8'(i * 29);
         i_alu_partner.regs[i] = xr[i];
      end
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_regs;
      t_arith;
      t_logic;
      give_verdict;
   end
   initial begin
      #200000;
      n_errors++;
      give_verdict;
   end
endmodule
`default_nettype wire
